// ### src/fcreg_cfg.svh
/*
  register offsets, command codes, status codes and timing counts of the
  flash controller register block.
  assumes: included by bare name from src/ files.
*/
`ifndef FCREG_CFG_SVH
`define FCREG_CFG_SVH
// ---------------------------------------------
// register file offsets
// ---------------------------------------------
`define FCREG_OFS_STATE 12'hff8
`define FCREG_OFS_PAGE 12'hff9
`define FCREG_OFS_KHZ_UPPER 12'hffa
`define FCREG_OFS_KHZ_LOWER 12'hffb
// ---------------------------------------------
// command codes
// ---------------------------------------------
`define FCREG_CMD_UNLOCK1 8'h73
`define FCREG_CMD_UNLOCK2 8'h8c
`define FCREG_CMD_PAGE_ERASE 8'h95
`define FCREG_CMD_MASS_ERASE 8'h63
`define FCREG_CMD_PROT_SEL 8'h5e
// ---------------------------------------------
// status codes
// ---------------------------------------------
`define FCREG_ST_LOCKED 6'h00
`define FCREG_ST_UNLOCK1 6'h01
`define FCREG_ST_UNLOCK2 6'h02
`define FCREG_ST_UNLOCKED 6'h03
`define FCREG_ST_PROT_SEL 6'h04
`define FCREG_ST_PROGRAM 3'h1
`define FCREG_ST_PAGE_ERASE 3'h2
`define FCREG_ST_MASS_ERASE 3'h4
// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define FCREG_INFO_BIT 7
`define FCREG_PAGE_MSB 6
`define FCREG_ADDR_PAGE_MSB 15
`define FCREG_ADDR_PAGE_LSB 9
`define FCREG_INFO_BASE 16'hfe00
`define FCREG_SECTOR_MSB 15
`define FCREG_SECTOR_LSB 13
`define FCREG_RST_BYTE 8'h00
// ---------------------------------------------
// timing: microseconds per program pulse or per erase repeat, times kHz over 1000 gives cycles
// ---------------------------------------------
`define FCREG_PROG_US 16'd40
`define FCREG_ERASE_US 16'd10
`define FCREG_ERASE_MS_REPS 16'd1000
`endif

// ### src/fcreg_pkg.sv
/*
  types of the flash controller register block.
  assumes: nothing beyond the cfg header.
*/
`default_nettype none
package fcreg_pkg;
  typedef enum logic [2:0] {
    FCREG_LOCKED,
    FCREG_UNLOCK1,
    FCREG_UNLOCK2,
    FCREG_UNLOCKED,
    FCREG_PROT_SEL,
    FCREG_PROGRAM,
    FCREG_PAGE_ERASE
  } fcreg_state_t;
endpackage
`default_nettype wire

// ### src/fcreg_timer.sv
/*
  pulse timer: counts microseconds from the kHz value, then units of them.
  assumes: start is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcreg_cfg.svh"
module fcreg_timer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] khz_in,
  input wire logic [15:0] units_in,
  input wire logic [15:0] reps_in,
  output logic busy_out,
  output logic done_out
);
  logic [15:0] us_q;
  logic [15:0] unit_q;
  logic [15:0] rep_q;
  // ---------------------------------------------
  // microsecond tick from kHz value
  // ---------------------------------------------
  wire logic [15:0] us_len = (khz_in < 16'd1000) ? 16'd1 : 16'(khz_in / 16'd1000);
  wire logic us_tick = busy_out && (us_q >= us_len - 16'd1);
  wire logic unit_end = us_tick && (unit_q >= units_in - 16'd1);
  wire logic last = unit_end && (rep_q >= reps_in - 16'd1);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      us_q <= 16'h0000;
      unit_q <= 16'h0000;
      rep_q <= 16'h0000;
    end else begin
      done_out <= last;
      if (start_in) begin
        busy_out <= 1'b1;
        us_q <= 16'h0000;
        unit_q <= 16'h0000;
        rep_q <= 16'h0000;
      end else if (busy_out) begin
        us_q <= us_tick ? 16'h0000 : us_q + 16'd1;
        if (us_tick) unit_q <= unit_end ? 16'h0000 : unit_q + 16'd1;
        if (unit_end) rep_q <= rep_q + 16'd1;
        if (last) busy_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/fcreg_top.sv
/*
  flash controller registers: state code, page choice, sector locks,
  clock kHz value, command sequencing and program/erase timing.
  assumes: cpu register port on clock_in; flash array driven from the
  program/erase outputs; one cycle register access strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fcreg_cfg.svh"
// Function
// [R1] status read anytime, writes hit command
// [R2] six-bit state codes for unlock sequence
// [R3] busy codes show program and erase
// [R4] 128 pages of 512 bytes
// [R5] page field drives address bits 15:9
// [R6] bit 7 maps info area high
// [R7] page choice hidden while protect selected
// [R8] protect register reachable after 5eh
// [R9] protect bits can only be set
// [R10] set protect bit refuses its sector
// [R11] upper and lower bytes form kHz
// [R12] software loads clock in kHz
// [R13] software keeps clock 20kHz to 20MHz
// [R14] command codes decoded as listed; mass erase 63h is not decoded and locks
// [R15] bad or misordered command locks
// [R16] page erase end returns to locked
// [R17] writes outside chosen page dropped
// [R18] pulse length scaled from kHz value
module fcreg_top (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic mem_wr_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic flash_prog_out,
  output logic flash_erase_out,
  output logic [15:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic info_area_select_out,
  output logic busy_out
);
  fcreg_pkg::fcreg_state_t state_q;
  fcreg_pkg::fcreg_state_t state_d;
  logic [7:0] page_choice_register_q;
  logic [7:0] sector_lock_register_q;
  logic [7:0] clock_khz_upper_q;
  logic [7:0] clock_khz_lower_q;
  logic [2:0] progress_q;
  logic start_q;
  logic [15:0] units_q;
  logic [15:0] reps_q;
  logic tmr_busy;
  logic tmr_done;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ---------------------------------------------
  // address decode
  // ---------------------------------------------
  // [R1] shared command/status slot
  wire logic wr_cmd = reg_wr_in && hit(reg_addr_in, `FCREG_OFS_STATE);
  wire logic wr_shared = reg_wr_in && hit(reg_addr_in, `FCREG_OFS_PAGE);
  // [R7] page choice hidden in protect mode
  wire logic prot_mode = (state_q == fcreg_pkg::FCREG_PROT_SEL);
  wire logic wr_page = wr_shared && !prot_mode;
  // [R8] protect reachable only after select
  wire logic wr_prot = wr_shared && prot_mode;
  wire logic op_busy = (state_q == fcreg_pkg::FCREG_PROGRAM) ||
                       (state_q == fcreg_pkg::FCREG_PAGE_ERASE);
  // [R11] high byte first kHz value
  wire logic [15:0] clock_khz_value = {clock_khz_upper_q, clock_khz_lower_q};

  // [R2] [R3] state and operation codes
  wire logic [5:0] controller_state_code =
    (state_q == fcreg_pkg::FCREG_UNLOCK1) ? `FCREG_ST_UNLOCK1 :
    (state_q == fcreg_pkg::FCREG_UNLOCK2) ? `FCREG_ST_UNLOCK2 :
    (state_q == fcreg_pkg::FCREG_UNLOCKED) ? `FCREG_ST_UNLOCKED :
    (state_q == fcreg_pkg::FCREG_PROT_SEL) ? `FCREG_ST_PROT_SEL :
    (state_q == fcreg_pkg::FCREG_PROGRAM) ? {`FCREG_ST_PROGRAM, progress_q} :
    (state_q == fcreg_pkg::FCREG_PAGE_ERASE) ? {`FCREG_ST_PAGE_ERASE, progress_q} :
    `FCREG_ST_LOCKED;

  // ---------------------------------------------
  // sector and page checks
  // ---------------------------------------------
  // [R5] page field on address 15:9
  wire logic [15:0] page_base = {page_choice_register_q[`FCREG_PAGE_MSB:0], 9'h000};
  wire logic [2:0] page_sector = page_base[`FCREG_SECTOR_MSB:`FCREG_SECTOR_LSB];
  wire logic [2:0] mem_sector = mem_addr_in[`FCREG_SECTOR_MSB:`FCREG_SECTOR_LSB];
  // [R10] locked sector refuses operation
  wire logic page_locked = sector_lock_register_q[page_sector];
  wire logic mem_locked = sector_lock_register_q[mem_sector];
  // [R17] only the chosen page programs
  wire logic in_page = (mem_addr_in[`FCREG_ADDR_PAGE_MSB:`FCREG_ADDR_PAGE_LSB] ==
                        page_choice_register_q[`FCREG_PAGE_MSB:0]);
  wire logic prog_ok = mem_wr_in && (state_q == fcreg_pkg::FCREG_UNLOCKED) &&
                       in_page && !mem_locked;
  wire logic erase_ok = !page_locked;

  // ---------------------------------------------
  // command sequencer
  // ---------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcreg_pkg::FCREG_PROGRAM: begin
        if (tmr_done) state_d = fcreg_pkg::FCREG_UNLOCKED;
      end
      fcreg_pkg::FCREG_PAGE_ERASE: begin
        // [R16] erase end relocks
        if (tmr_done) state_d = fcreg_pkg::FCREG_LOCKED;
      end
      default: begin
        if (wr_cmd) begin
          // [R15] default locks controller
          state_d = fcreg_pkg::FCREG_LOCKED;
          // [R14] command code decode
          if (reg_wdata_in == `FCREG_CMD_UNLOCK1 && state_q == fcreg_pkg::FCREG_LOCKED)
            state_d = fcreg_pkg::FCREG_UNLOCK1;
          else if (reg_wdata_in == `FCREG_CMD_UNLOCK2 && state_q == fcreg_pkg::FCREG_UNLOCK1)
            state_d = fcreg_pkg::FCREG_UNLOCK2;
          else if (reg_wdata_in == `FCREG_CMD_PAGE_ERASE &&
                   state_q == fcreg_pkg::FCREG_UNLOCKED && erase_ok)
            state_d = fcreg_pkg::FCREG_PAGE_ERASE;
          else if (reg_wdata_in == `FCREG_CMD_PROT_SEL && state_q == fcreg_pkg::FCREG_LOCKED)
            state_d = fcreg_pkg::FCREG_PROT_SEL;
        end else if (wr_page && state_q == fcreg_pkg::FCREG_UNLOCK2) begin
          // second page write unlocks only if same page
          state_d = (reg_wdata_in == page_choice_register_q) ?
                    fcreg_pkg::FCREG_UNLOCKED : fcreg_pkg::FCREG_LOCKED;
        end else if (prog_ok) begin
          state_d = fcreg_pkg::FCREG_PROGRAM;
        end
      end
    endcase
  end

  // [R18] pulse length from kHz value
  wire logic start_d = (state_d != state_q) &&
    (state_d == fcreg_pkg::FCREG_PROGRAM || state_d == fcreg_pkg::FCREG_PAGE_ERASE);
  wire logic [15:0] units_d = (state_d == fcreg_pkg::FCREG_PROGRAM) ?
                              `FCREG_PROG_US : `FCREG_ERASE_US;
  wire logic [15:0] reps_d = (state_d == fcreg_pkg::FCREG_PROGRAM) ?
                             16'd1 : `FCREG_ERASE_MS_REPS;

  fcreg_timer u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(start_q),
    .khz_in(clock_khz_value),
    .units_in(units_q),
    .reps_in(reps_q),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // ---------------------------------------------
  // read data
  // ---------------------------------------------
  wire logic [7:0] rd_mux =
    hit(reg_addr_in, `FCREG_OFS_STATE) ? {2'b00, controller_state_code} :
    hit(reg_addr_in, `FCREG_OFS_PAGE) ?
      (prot_mode ? sector_lock_register_q : page_choice_register_q) :
    hit(reg_addr_in, `FCREG_OFS_KHZ_UPPER) ? clock_khz_upper_q :
    hit(reg_addr_in, `FCREG_OFS_KHZ_LOWER) ? clock_khz_lower_q : 8'h00;

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= fcreg_pkg::FCREG_LOCKED;
      page_choice_register_q <= `FCREG_RST_BYTE;
      sector_lock_register_q <= `FCREG_RST_BYTE;
      clock_khz_upper_q <= `FCREG_RST_BYTE;
      clock_khz_lower_q <= `FCREG_RST_BYTE;
      progress_q <= 3'h0;
      start_q <= 1'b0;
      units_q <= 16'h0001;
      reps_q <= 16'h0001;
      reg_rdata_out <= `FCREG_RST_BYTE;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      if (start_d) begin
        units_q <= units_d;
        reps_q <= reps_d;
      end
      progress_q <= tmr_busy ? progress_q + 3'h1 : 3'h0;
      // [R1] status readable any time
      if (reg_rd_in) reg_rdata_out <= rd_mux;
      // [R4] one page of 128 chosen
      if (wr_page && !op_busy) page_choice_register_q <= reg_wdata_in;
      // [R9] write ones only
      if (wr_prot) sector_lock_register_q <= sector_lock_register_q | reg_wdata_in;
      if (reg_wr_in && hit(reg_addr_in, `FCREG_OFS_KHZ_UPPER)) clock_khz_upper_q <= reg_wdata_in;
      if (reg_wr_in && hit(reg_addr_in, `FCREG_OFS_KHZ_LOWER)) clock_khz_lower_q <= reg_wdata_in;
    end
  end

  // ---------------------------------------------
  // flash array drive
  // ---------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flash_prog_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_addr_out <= 16'h0000;
      flash_wdata_out <= 8'hff;
      info_area_select_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      flash_prog_out <= (state_d == fcreg_pkg::FCREG_PROGRAM);
      // [R5] page erase writes ffh to page
      flash_erase_out <= (state_d == fcreg_pkg::FCREG_PAGE_ERASE);
      busy_out <= (state_d == fcreg_pkg::FCREG_PROGRAM) ||
                  (state_d == fcreg_pkg::FCREG_PAGE_ERASE);
      // [R6] info area over fe00h-ffffh
      info_area_select_out <= page_choice_register_q[`FCREG_INFO_BIT];
      if (prog_ok) begin
        flash_addr_out <= mem_addr_in;
        flash_wdata_out <= mem_wdata_in;
      end else if (start_d) begin
        flash_addr_out <= page_base;
        flash_wdata_out <= 8'hff;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/fcreg_asserts.sv
/*
  port checker for the flash controller register block.
  assumes: bound to fcreg_top from the testbench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module fcreg_asserts (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic mem_wr_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic flash_prog_out,
  input wire logic flash_erase_out,
  input wire logic [15:0] flash_addr_out,
  input wire logic [7:0] flash_wdata_out,
  input wire logic info_area_select_out,
  input wire logic busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire rd_state = reg_rd_in && reg_addr_in == 12'hff8;
  wire rd_unmapped = reg_rd_in && reg_addr_in < 12'hff8;
  sequence s_prog_hold;
    (flash_prog_out && $stable(flash_addr_out) && $stable(flash_wdata_out)) [*4];
  endsequence
  a_prog_busy: assert property (flash_prog_out |-> busy_out)
    else $error("program pulse without busy");
  a_erase_busy: assert property (flash_erase_out |-> busy_out)
    else $error("erase pulse without busy");
  a_erase_page: assert property (flash_erase_out |->
    flash_wdata_out == 8'hff && flash_addr_out[8:0] == 9'h000)
    else $error("erase not page aligned or not ones");
  a_no_overlap: assert property (!(flash_prog_out && flash_erase_out))
    else $error("program and erase together");
  a_prog_launch: assert property ($rose(flash_prog_out) |->
    $past(mem_wr_in) && flash_addr_out == $past(mem_addr_in)
    && flash_wdata_out == $past(mem_wdata_in))
    else $error("program pulse not tied to write");
  a_prog_stable: assert property ($rose(flash_prog_out) |=> s_prog_hold)
    else $error("program pulse too short or unstable");
  a_read_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (rd_unmapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_busy_code: assert property (busy_out && rd_state |=>
    reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[5:3] != 3'b000)
    else $error("busy state code wrong");
endmodule
`default_nettype wire

// ### tb/testbench.sv
/*
  self-checking testbench of the flash controller register block.
  assumes: kHz value 1000, so one microsecond is one clock cycle;
  a kHz value of 2000 doubles every pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic mem_wr_in = 1'b0;
  logic [15:0] mem_addr_in = 16'h0000;
  logic [7:0] mem_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic flash_prog_out, flash_erase_out, info_area_select_out, busy_out;
  logic [15:0] flash_addr_out;
  logic [7:0] flash_wdata_out;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 clock_in = ~clock_in;
  fcreg_top fcreg_top_i (.clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .mem_wr_in(mem_wr_in), .mem_addr_in(mem_addr_in),
    .mem_wdata_in(mem_wdata_in), .flash_prog_out(flash_prog_out),
    .flash_erase_out(flash_erase_out), .flash_addr_out(flash_addr_out),
    .flash_wdata_out(flash_wdata_out), .info_area_select_out(info_area_select_out),
    .busy_out(busy_out));
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_out & m}, {8'h00, e});
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    mem_wr_in <= 1'b1;
    mem_addr_in <= a;
    mem_wdata_in <= d;
    @(posedge clock_in);
    mem_wr_in <= 1'b0;
    #1;
  endtask
  task automatic idle(input int lo, input int hi);
    int n;
    n = 0;
    while (busy_out === 1'b1 && n < 20000) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask
  task automatic unlock(input logic [7:0] p);
    wr(12'hff8, 8'h00);
    wr(12'hff9, p);
    wr(12'hff8, 8'h73);
    rd(12'hff8, 8'h01);
    wr(12'hff8, 8'h8c);
    rd(12'hff8, 8'h02);
    wr(12'hff9, p);
    rd(12'hff8, 8'h03);
  endtask
  // ---------------------------------------------
  // timeout
  // ---------------------------------------------
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(12'hff8, 8'h00);
    rd(12'hff9, 8'h00);
    rd(12'hffa, 8'h00);
    rd(12'hffb, 8'h00);
    rd(12'h100, 8'h00);
    $display("reset values done");
    wr(12'hffb, 8'h34);
    rd(12'hffb, 8'h34);
    wr(12'hffa, 8'h03);
    wr(12'hffb, 8'he8);
    rd(12'hffa, 8'h03);
    $display("clock value done");
    wr(12'hff8, 8'h5e);
    rd(12'hff8, 8'h04);
    wr(12'hff9, 8'h01);
    wr(12'hff9, 8'h00);
    rd(12'hff9, 8'h01);
    wr(12'hff8, 8'h00);
    rd(12'hff9, 8'h00);
    $display("sector lock done");
    unlock(8'h21);
    mw(16'h4403, 8'h5a);
    chk({15'h0, flash_prog_out}, 16'h0000);
    mw(16'h4203, 8'h5a);
    chk({flash_prog_out, busy_out, 6'h0, flash_wdata_out}, 16'hc05a);
    chk(flash_addr_out, 16'h4203);
    rd(12'hff8, 8'h08, 8'hf8);
    idle(38, 44);
    rd(12'hff8, 8'h03);
    $display("program done");
    wr(12'hffb, 8'hd0);
    wr(12'hffa, 8'h07);
    unlock(8'h21);
    mw(16'h4205, 8'h33);
    chk({flash_prog_out, 7'h0, flash_wdata_out}, 16'h8033);
    idle(78, 86);
    wr(12'hffa, 8'h03);
    wr(12'hffb, 8'he8);
    $display("scaled program done");
    unlock(8'h21);
    wr(12'hff8, 8'h95);
    repeat (2) @(posedge clock_in);
    #1;
    chk({flash_erase_out, 7'h0, flash_wdata_out}, 16'h80ff);
    chk(flash_addr_out, 16'h4200);
    rd(12'hff8, 8'h10, 8'hf8);
    idle(9990, 10010);
    rd(12'hff8, 8'h00);
    $display("page erase done");
    unlock(8'h05);
    wr(12'hff8, 8'h95);
    repeat (2) @(posedge clock_in);
    #1;
    chk({15'h0, flash_erase_out}, 16'h0000);
    rd(12'hff8, 8'h00);
    wr(12'hff8, 8'h73);
    wr(12'hff8, 8'h11);
    rd(12'hff8, 8'h00);
    wr(12'hff8, 8'h8c);
    rd(12'hff8, 8'h00);
    wr(12'hff8, 8'h63);
    rd(12'hff8, 8'h00);
    $display("refusals done");
    wr(12'hff9, 8'h85);
    rd(12'hff9, 8'h85);
    chk({15'h0, info_area_select_out}, 16'h0001);
    $display("info area done");
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(12'hff9, 8'h00);
    rd(12'hffa, 8'h00);
    chk({15'h0, info_area_select_out}, 16'h0000);
    wr(12'hff8, 8'h5e);
    rd(12'hff9, 8'h00);
    wr(12'hff8, 8'h00);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule
bind fcreg_top fcreg_asserts fcreg_asserts_i (.clock_in(clock_in), .rst_in(rst_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .mem_wr_in(mem_wr_in),
  .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in),
  .flash_prog_out(flash_prog_out), .flash_erase_out(flash_erase_out),
  .flash_addr_out(flash_addr_out), .flash_wdata_out(flash_wdata_out),
  .info_area_select_out(info_area_select_out), .busy_out(busy_out));
`default_nettype wire
